// ### design/aspm_map.vh
// register offsets, field positions, reset values and timing counts for the alarm/power block
`ifndef ASPM_MAP_VH
`define ASPM_MAP_VH
`define ASPM_ADDR_W           12
`define ASPM_OFS_PWR_A        12'h037
`define ASPM_OFS_SOFT_TRIG    12'h06C
`define ASPM_OFS_PWR_B        12'h29A
`define ASPM_OFS_PWR_C        12'h29B
`define ASPM_OFS_PWR_D        12'h29C
`define ASPM_OFS_LINK_CTRL    12'h200
`define ASPM_OFS_ALM_FLAGS    12'h2C0
`define ASPM_OFS_ALARM_CAUSE_MASK     12'h2C1
`define ASPM_OFS_ALM_SUMMARY  12'h2C2
`define ASPM_OFS_LANE_FIFO    12'h2C3
`define ASPM_OFS_CAL_CTRL     12'h2D0
`define ASPM_OFS_DEV_CTRL     12'h2D1
`define ASPM_RST_PWR_A        8'h4B
`define ASPM_RST_PWR_B        8'h0F
`define ASPM_RST_PWR_C        8'h04
`define ASPM_RST_PWR_D        8'h1B
`define ASPM_RST_ALARM_CAUSE_MASK     8'h00
`define ASPM_ALM_CPLL         0
`define ASPM_ALM_SPLL         1
`define ASPM_ALM_LINK         2
`define ASPM_ALM_SYSREF       3
`define ASPM_ALM_CLK          4
`define ASPM_ALM_FIFO         5
`define ASPM_CAL_EN_BIT       0
`define ASPM_CAL_BG_BIT       1
`define ASPM_CAL_LPBG_BIT     2
`define ASPM_CAL_LPTRIG_BIT   3
`define ASPM_CAL_STSEL_BIT    4
`define ASPM_DEV_ENC64_BIT    0
`define ASPM_DEV_SC1_BIT      1
`define ASPM_DEV_PDA_BIT      2
`define ASPM_DEV_PDB_BIT      3
`define ASPM_DEV_GPD_BIT      4
`define ASPM_CLK_NS           100
`define ASPM_TRANS_MIN_NS     50000
`define ASPM_TRANS_MAX_NS     100000
`define ASPM_TRANS_MIN_CYC    ((`ASPM_TRANS_MIN_NS + `ASPM_CLK_NS - 1) / `ASPM_CLK_NS)
`define ASPM_TRANS_MAX_CYC    (`ASPM_TRANS_MAX_NS / `ASPM_CLK_NS)
`endif

// ### design/aspm_top.v
// alarm aggregation, local frame counter, clock/fifo upset and power mode control
`timescale 1ns/100ps
`default_nettype none
`include "aspm_map.vh"

module aspm_top #(
   parameter LANES     = 8,
   parameter LMFC_W    = 8,
   parameter TRANS_MIN = `ASPM_TRANS_MIN_CYC,
   parameter TRANS_MAX = `ASPM_TRANS_MAX_CYC
) (
   // clock and reset
   input  wire                    clock_i,
   input  wire                    rstn_i,
   // register port
   input  wire                    reg_wr_i,
   input  wire                    reg_rd_i,
   input  wire [`ASPM_ADDR_W-1:0] reg_addr_i,
   input  wire [7:0]              reg_wdata_i,
   output reg  [7:0]              reg_rdata_o,
   // pins from outside
   input  wire                    sysref_i,
   input  wire                    sync_n_i,
   input  wire                    powerdown_pin_i,
   input  wire                    calibration_trigger_pin_i,
   // internal event sources
   input  wire                    cpll_locked_i,
   input  wire                    spll_locked_i,
   input  wire                    link_in_data_i,
   input  wire                    sysref_realign_i,
   input  wire                    clk_a_phase_i,
   input  wire                    clk_b_phase_i,
   input  wire [LANES-1:0]        lane_fifo_err_i,
   input  wire [LMFC_W-1:0]       lmfc_period_i,
   // outputs
   output reg                     calibration_status_pin_o,
   output reg                     lmfc_edge_o,
   output reg                     link_enable_o,
   output reg                     fifo_reset_o,
   output reg                     cgs_start_o,
   output reg                     core_transition_o,
   output reg  [7:0]              power_trade_reg_a_o,
   output reg  [7:0]              power_trade_reg_b_o,
   output reg  [7:0]              power_trade_reg_c_o,
   output reg  [7:0]              power_trade_reg_d_o
);
   // two-flop synchronisers for pins
   // only the second flop of each pair feeds logic, keeping metastability out
   reg [1:0] sysref_s_q;
   reg [1:0] sync_s_q;
   reg [1:0] pd_s_q;
   reg [1:0] trig_s_q;
   reg       sysref_d1_q;
   reg       sync_d1_q;
   reg       pd_d1_q;
   reg       trig_d1_q;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sysref_s_q  <= 2'h0;
         sync_s_q    <= 2'h3;
         pd_s_q      <= 2'h0;
         trig_s_q    <= 2'h0;
         sysref_d1_q <= 1'b0;
         sync_d1_q   <= 1'b1;
         pd_d1_q     <= 1'b0;
         trig_d1_q   <= 1'b0;
      end else begin
         sysref_s_q  <= {sysref_s_q[0], sysref_i};
         sync_s_q    <= {sync_s_q[0], sync_n_i};
         pd_s_q      <= {pd_s_q[0], powerdown_pin_i};
         trig_s_q    <= {trig_s_q[0], calibration_trigger_pin_i};
         sysref_d1_q <= sysref_s_q[1];
         sync_d1_q   <= sync_s_q[1];
         pd_d1_q     <= pd_s_q[1];
         trig_d1_q   <= trig_s_q[1];
      end
   end
   wire sysref_rise = sysref_s_q[1] & ~sysref_d1_q;
   wire sync_fall   = ~sync_s_q[1] & sync_d1_q;
   wire trig_rise   = trig_s_q[1] & ~trig_d1_q;
   wire pd_now      = pd_s_q[1];

   // control registers
   reg [7:0]       alm_flags_q;
   reg [7:0]       alarm_cause_mask_q;
   reg [7:0]       cal_ctrl_q;
   reg [7:0]       dev_ctrl_q;
   reg [LANES-1:0] lane_flags_q;
   reg             link_en_q;

   wire wr_flags = reg_wr_i && reg_addr_i == `ASPM_OFS_ALM_FLAGS;
   wire wr_lane  = reg_wr_i && reg_addr_i == `ASPM_OFS_LANE_FIFO;
   wire wr_soft  = reg_wr_i && reg_addr_i == `ASPM_OFS_SOFT_TRIG;
   wire wr_link  = reg_wr_i && reg_addr_i == `ASPM_OFS_LINK_CTRL;
   wire enc64    = dev_ctrl_q[`ASPM_DEV_ENC64_BIT];
   wire subcl1   = dev_ctrl_q[`ASPM_DEV_SC1_BIT];
   wire gpd      = dev_ctrl_q[`ASPM_DEV_GPD_BIT] | pd_now;
   // compare is only meaningful with both channels running
   wire both_ch  = ~dev_ctrl_q[`ASPM_DEV_PDA_BIT] & ~dev_ctrl_q[`ASPM_DEV_PDB_BIT];

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_trade_reg_a_o <= `ASPM_RST_PWR_A;
         power_trade_reg_b_o <= `ASPM_RST_PWR_B;
         power_trade_reg_c_o <= `ASPM_RST_PWR_C;
         power_trade_reg_d_o <= `ASPM_RST_PWR_D;
         alarm_cause_mask_q          <= `ASPM_RST_ALARM_CAUSE_MASK;
         cal_ctrl_q          <= 8'h00;
         dev_ctrl_q          <= 8'h00;
         link_en_q           <= 1'b0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `ASPM_OFS_PWR_A:     power_trade_reg_a_o <= reg_wdata_i;
            `ASPM_OFS_PWR_B:     power_trade_reg_b_o <= reg_wdata_i;
            `ASPM_OFS_PWR_C:     power_trade_reg_c_o <= reg_wdata_i;
            `ASPM_OFS_PWR_D:     power_trade_reg_d_o <= reg_wdata_i;
            `ASPM_OFS_ALARM_CAUSE_MASK:  alarm_cause_mask_q          <= reg_wdata_i;
            `ASPM_OFS_CAL_CTRL:  cal_ctrl_q          <= reg_wdata_i;
            `ASPM_OFS_DEV_CTRL:  dev_ctrl_q          <= reg_wdata_i;
            `ASPM_OFS_LINK_CTRL: link_en_q           <= reg_wdata_i[0];
            default: ;
         endcase
      end
   end

   // fifo reset on a 0-then-1 link enable toggle; link held in reset while 0
   // the toggle is the only recovery from a lane fifo upset
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link_enable_o <= 1'b0;
         fifo_reset_o  <= 1'b1;
      end else begin
         link_enable_o <= link_en_q;
         fifo_reset_o  <= ~link_en_q | (wr_link & reg_wdata_i[0] & ~link_en_q);
      end
   end

   // clock compare: mismatch held one cycle counts as an upset
   reg clk_mis_q;
   reg gpd_q;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clk_mis_q <= 1'b0;
         gpd_q     <= 1'b0;
      end else begin
         clk_mis_q <= (clk_a_phase_i ^ clk_b_phase_i) & link_en_q & both_ch;
         gpd_q     <= gpd;
      end
   end
   // leaving global power-down can disturb clock compare
   wire gpd_exit = gpd_q & ~gpd;

   // link alarm only counts while the link is meant to run
   wire [7:0] alm_cause;
   assign alm_cause[`ASPM_ALM_CPLL]   = ~cpll_locked_i;
   assign alm_cause[`ASPM_ALM_SPLL]   = ~spll_locked_i;
   assign alm_cause[`ASPM_ALM_LINK]   = link_en_q & ~link_in_data_i;
   assign alm_cause[`ASPM_ALM_SYSREF] = sysref_realign_i;
   assign alm_cause[`ASPM_ALM_CLK]    = clk_mis_q | gpd_exit;
   assign alm_cause[`ASPM_ALM_FIFO]   = |(lane_fifo_err_i & {LANES{link_en_q}});
   assign alm_cause[7:6]              = 2'h0;

   // sticky flags: set wins over write-one clear, zero leaves bit alone
   // lane flags survive the fifo reset; only a host write or rstn_i clears them
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         alm_flags_q  <= 8'h00;
         lane_flags_q <= {LANES{1'b0}};
      end else begin
         alm_flags_q  <= (alm_flags_q & ~({8{wr_flags}} & reg_wdata_i))
                         | alm_cause;
         lane_flags_q <= (lane_flags_q & ~({LANES{wr_lane}} & reg_wdata_i[LANES-1:0]))
                         | (lane_fifo_err_i & {LANES{link_en_q}});
      end
   end

   wire [7:0] alm_summary = alm_flags_q & ~alarm_cause_mask_q;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         calibration_status_pin_o <= 1'b0;
      end else begin
         calibration_status_pin_o <= cal_ctrl_q[`ASPM_CAL_STSEL_BIT] & (|alm_summary);
      end
   end

   // local multiframe / extended multiblock counter
   // one counter: multiframe count in 8b/10b, extended multiblock count in 64b/66b
   reg [LMFC_W-1:0] lmfc_q;
   wire lmfc_wrap = (lmfc_q >= lmfc_period_i);

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lmfc_q      <= {LMFC_W{1'b0}};
         lmfc_edge_o <= 1'b0;
      end else begin
         // in subclass 0 sysref is ignored: counter free-runs, keeping its current phase
         if (subcl1 && sysref_rise)
            lmfc_q <= {LMFC_W{1'b0}};
         else if (lmfc_wrap)
            lmfc_q <= {LMFC_W{1'b0}};
         else
            lmfc_q <= lmfc_q + {{(LMFC_W-1){1'b0}}, 1'b1};
         lmfc_edge_o <= (subcl1 && sysref_rise) | lmfc_wrap;
      end
   end

   // sync request starts code group sync in 8b/10b only
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cgs_start_o <= 1'b0;
      end else begin
         cgs_start_o <= link_en_q & ~enc64 & sync_fall;
      end
   end

   // low power trigger: transition between min and max count after trigger
   localparam CNT_W = 16;
   // fire at the window's start; a min set above the max falls back to the max
   localparam TRANS_SEL = (TRANS_MIN <= TRANS_MAX) ? TRANS_MIN : TRANS_MAX;
   localparam [CNT_W-1:0] TRANS_AT = TRANS_SEL[CNT_W-1:0];

   reg [CNT_W-1:0] trans_cnt_q;
   reg             trans_busy_q;
   wire lp_bg   = cal_ctrl_q[`ASPM_CAL_EN_BIT] & cal_ctrl_q[`ASPM_CAL_LPBG_BIT];
   wire lowpower_trigger_control = lp_bg & cal_ctrl_q[`ASPM_CAL_LPTRIG_BIT];
   wire bg_cal  = cal_ctrl_q[`ASPM_CAL_EN_BIT] &
                  (cal_ctrl_q[`ASPM_CAL_BG_BIT] | cal_ctrl_q[`ASPM_CAL_LPBG_BIT]);
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trans_cnt_q       <= {CNT_W{1'b0}};
         trans_busy_q      <= 1'b0;
         core_transition_o <= 1'b0;
      end else begin
         core_transition_o <= 1'b0;
         if (!bg_cal) begin
            trans_busy_q <= 1'b0;
            trans_cnt_q  <= {CNT_W{1'b0}};
         end else if (trans_busy_q) begin
            if (trans_cnt_q == TRANS_AT - 16'h0001) begin
               trans_busy_q      <= 1'b0;
               core_transition_o <= 1'b1;
            end
            trans_cnt_q <= trans_cnt_q + 16'h0001;
         end else if (lowpower_trigger_control && (trig_rise || wr_soft)) begin
            trans_busy_q <= 1'b1;
            trans_cnt_q  <= {CNT_W{1'b0}};
         end
      end
   end

   // register reads
   // soft trigger is write only and reads as zero through the default
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i) begin
         case (reg_addr_i)
            `ASPM_OFS_PWR_A:       reg_rdata_o <= power_trade_reg_a_o;
            `ASPM_OFS_PWR_B:       reg_rdata_o <= power_trade_reg_b_o;
            `ASPM_OFS_PWR_C:       reg_rdata_o <= power_trade_reg_c_o;
            `ASPM_OFS_PWR_D:       reg_rdata_o <= power_trade_reg_d_o;
            `ASPM_OFS_ALM_FLAGS:   reg_rdata_o <= alm_flags_q;
            `ASPM_OFS_ALARM_CAUSE_MASK:    reg_rdata_o <= alarm_cause_mask_q;
            `ASPM_OFS_ALM_SUMMARY: reg_rdata_o <= {7'h00, |alm_summary};
            `ASPM_OFS_LANE_FIFO:   reg_rdata_o <= lane_flags_q;
            `ASPM_OFS_CAL_CTRL:    reg_rdata_o <= cal_ctrl_q;
            `ASPM_OFS_DEV_CTRL:    reg_rdata_o <= dev_ctrl_q;
            `ASPM_OFS_LINK_CTRL:   reg_rdata_o <= {7'h00, link_en_q};
            default:               reg_rdata_o <= 8'h00;
         endcase
      end
   end
endmodule // aspm_top

`default_nettype wire

// ### verification/aspm_chk.sv
// port-level assertions for the alarm/power block
`timescale 1ns/100ps
`default_nettype none
`include "aspm_map.vh"
module aspm_chk (
   // clock and reset
   input wire logic                    clock_i,
   input wire logic                    rstn_i,
   // register port
   input wire logic                    reg_wr_i,
   input wire logic                    reg_rd_i,
   input wire logic [`ASPM_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0]              reg_wdata_i,
   // watched outputs
   input wire logic [7:0]              power_trade_reg_a_o,
   input wire logic [7:0]              power_trade_reg_c_o,
   input wire logic                    link_enable_o,
   input wire logic                    fifo_reset_o,
   input wire logic                    cgs_start_o,
   input wire logic                    core_transition_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   chk_fifo_held: assert property (!link_enable_o |-> fifo_reset_o)
      else $error("fifo reset low with link off");
   chk_fifo_release: assert property ($fell(fifo_reset_o) |-> link_enable_o)
      else $error("fifo reset dropped without link on");
   chk_link_on: assert property ((reg_wr_i && reg_addr_i == `ASPM_OFS_LINK_CTRL
      && reg_wdata_i[0]) |-> ##[1:2] link_enable_o) else $error("link enable not taken");
   chk_cgs_pulse: assert property (cgs_start_o |=> !cgs_start_o)
      else $error("sync start longer than one cycle");
   chk_cgs_link: assert property (cgs_start_o |-> link_enable_o)
      else $error("sync start with link off");
   chk_trans_pulse: assert property (core_transition_o |=> !core_transition_o)
      else $error("core transition longer than one cycle");
   chk_pwr_reset: assert property ($rose(rstn_i)
      |-> power_trade_reg_a_o == `ASPM_RST_PWR_A && power_trade_reg_c_o == `ASPM_RST_PWR_C)
      else $error("power regs not at defaults");
   chk_pwr_write: assert property ((reg_wr_i && reg_addr_i == `ASPM_OFS_PWR_C)
      |=> power_trade_reg_c_o == $past(reg_wdata_i)) else $error("glitch trade reg not written");
   chk_pwr_hold: assert property (!(reg_wr_i && reg_addr_i == `ASPM_OFS_PWR_A)
      |=> $stable(power_trade_reg_a_o)) else $error("power reg changed without write");
endmodule // aspm_chk
bind aspm_top aspm_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .power_trade_reg_a_o(power_trade_reg_a_o), .power_trade_reg_c_o(power_trade_reg_c_o),
   .link_enable_o(link_enable_o), .fifo_reset_o(fifo_reset_o), .cgs_start_o(cgs_start_o),
   .core_transition_o(core_transition_o));
`default_nettype wire

// ### verification/aspm_rx_model.sv
// receiver-side model: sync request and elastic-buffer release
`timescale 1ns/100ps
`default_nettype none
module aspm_rx_model (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   input  wire logic link_enable_i,
   input  wire logic cgs_start_i,
   input  wire logic lmfc_edge_i,
   output var  logic sync_n_o,
   output var  logic release_o
);
   logic aligned_q;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_n_o <= 1'b1;
         aligned_q <= 1'b0;
         release_o <= 1'b0;
      end else begin
         // keep requesting until the transmitter answers
         sync_n_o <= !(link_enable_i && !aligned_q);
         aligned_q <= link_enable_i && (aligned_q || cgs_start_i);
         // delay of zero: release on the edge, only once every lane is in
         release_o <= lmfc_edge_i && aligned_q;
      end
   end
endmodule // aspm_rx_model
`default_nettype wire

// ### verification/aspm_top_tb.sv
// self-checking bench for the alarm/power block
`timescale 1ns/100ps
`default_nettype none
`include "aspm_map.vh"
module aspm_top_tb;
   localparam int TMIN = 5;
   localparam int TMAX = 10;
   // address, write data, expected read-back
   localparam logic [27:0] ROWS [12] = '{28'h037_46_46, 28'h29A_06_06, 28'h29B_00_00,
      28'h29C_14_14, 28'h037_4B_4B, 28'h29A_0F_0F, 28'h29B_04_04, 28'h29C_1B_1B,
      28'h3FF_AA_00, 28'h06C_01_00, 28'h2C1_3F_3F, 28'h2C1_00_00};
   logic        clk = 0, rstn = 0, wr = 0, rd = 0, sref = 0, pdp = 0, tpin = 0;
   logic        cpll = 1, spll = 1, indata = 1, realign = 0, cb = 0;
   logic [11:0] addr = 0;
   logic [7:0]  wd = 0, lerr = 0, rdat, pa, pb, pc, pd, rv;
   logic        stat, edg, len, frst, cgs, trans, syn;
   int          err_count = 0, tests_run = 0, k, i, n;
   aspm_top #(.TRANS_MIN(TMIN), .TRANS_MAX(TMAX)) u_dut (.clock_i(clk), .rstn_i(rstn),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .sysref_i(sref), .sync_n_i(syn), .powerdown_pin_i(pdp), .calibration_trigger_pin_i(tpin),
      .cpll_locked_i(cpll), .spll_locked_i(spll), .link_in_data_i(indata),
      .sysref_realign_i(realign), .clk_a_phase_i(1'b0), .clk_b_phase_i(cb),
      .lane_fifo_err_i(lerr), .lmfc_period_i(8'h10), .calibration_status_pin_o(stat),
      .lmfc_edge_o(edg), .link_enable_o(len), .fifo_reset_o(frst), .cgs_start_o(cgs),
      .core_transition_o(trans), .power_trade_reg_a_o(pa), .power_trade_reg_b_o(pb),
      .power_trade_reg_c_o(pc), .power_trade_reg_d_o(pd));
   aspm_rx_model u_rx (.clock_i(clk), .rstn_i(rstn), .link_enable_i(len), .cgs_start_i(cgs),
      .lmfc_edge_i(edg), .sync_n_o(syn), .release_o());
   task conclude;
      $display("mismatches %0d, checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data holds, so sampling one edge late is safe
   task rreg(input logic [11:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1 rv = rdat;
   endtask
   task wait_pulse(input int w, input int lim);
      for (k = 0; k < lim; k++) begin
         @(posedge clk);
         #1;
         if ((w == 0 ? cgs : w == 1 ? edg : trans) === 1'b1) return;
      end
      err_count++;
      $display("Error %0t: pulse wait ran out", $time);
      conclude;
   endtask
   task cause(input int c, input logic v);
      case (c)
         0: cpll <= !v;
         1: spll <= !v;
         3: realign <= v;
         4: cb <= v;
         5: lerr <= {v, 7'h00};
      endcase
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      #1;
      check(pa, `ASPM_RST_PWR_A);
      check(pb, `ASPM_RST_PWR_B);
      check(pd, `ASPM_RST_PWR_D);
      for (i = 0; i < 12; i++) begin
         wreg(ROWS[i][27:16], ROWS[i][15:8]);
         rreg(ROWS[i][27:16]);
         check(rv, ROWS[i][7:0]);
      end
      wreg(`ASPM_OFS_LINK_CTRL, 8'h00);
      wreg(`ASPM_OFS_DEV_CTRL, 8'h00);
      wreg(`ASPM_OFS_LINK_CTRL, 8'h01);
      wreg(`ASPM_OFS_ALM_FLAGS, 8'hFF);
      for (i = 0; i < 6; i++) begin
         if (i == 2) continue;
         @(posedge clk);
         cause(i, 1'b1);
         @(posedge clk);
         cause(i, 1'b0);
         rreg(`ASPM_OFS_ALM_FLAGS);
         check(rv, 8'h01 << i);
         wreg(`ASPM_OFS_ALM_FLAGS, 8'h01 << i);
         rreg(`ASPM_OFS_ALM_FLAGS);
         check(rv, 8'h00);
      end
      rreg(`ASPM_OFS_LANE_FIFO);
      check(rv, 8'h80);
      wreg(`ASPM_OFS_LINK_CTRL, 8'h00);
      wreg(`ASPM_OFS_CAL_CTRL, 8'h10);
      @(posedge clk);
      cause(0, 1'b1);
      @(posedge clk);
      cause(0, 1'b0);
      wreg(`ASPM_OFS_ALM_FLAGS, 8'h00);
      rreg(`ASPM_OFS_ALM_FLAGS);
      check(rv, 8'h01);
      rreg(`ASPM_OFS_ALM_SUMMARY);
      check(rv, 8'h01);
      check({7'h0, stat}, 8'h01);
      wreg(`ASPM_OFS_ALARM_CAUSE_MASK, 8'h01);
      rreg(`ASPM_OFS_ALM_SUMMARY);
      check({rv[0], stat}, 8'h00);
      wreg(`ASPM_OFS_ALARM_CAUSE_MASK, 8'h00);
      wreg(`ASPM_OFS_ALM_FLAGS, 8'h01);
      @(posedge clk);
      pdp <= 1'b1;
      repeat (6) @(posedge clk);
      pdp <= 1'b0;
      repeat (6) @(posedge clk);
      rreg(`ASPM_OFS_ALM_FLAGS);
      check(rv & 8'h10, 8'h10);
      wreg(`ASPM_OFS_ALM_FLAGS, 8'h10);
      wreg(`ASPM_OFS_LINK_CTRL, 8'h01);
      wait_pulse(0, 20);
      check({len, frst}, 8'h02);
      @(posedge clk);
      indata <= 1'b0;
      @(posedge clk);
      indata <= 1'b1;
      rreg(`ASPM_OFS_ALM_FLAGS);
      check(rv, 8'h04);
      wreg(`ASPM_OFS_ALM_FLAGS, 8'h04);
      wreg(`ASPM_OFS_LINK_CTRL, 8'h00);
      rreg(`ASPM_OFS_LINK_CTRL);
      check({len, frst}, 8'h01);
      for (i = 2; i < 4; i++) begin
         wreg(`ASPM_OFS_DEV_CTRL, i[7:0]);
         wait_pulse(1, 40);
         repeat (8) @(posedge clk);
         sref <= 1'b1;
         wait_pulse(1, 6);
         check(k[7:0], 8'h02);
         @(posedge clk);
         sref <= 1'b0;
      end
      wreg(`ASPM_OFS_DEV_CTRL, 8'h00);
      wait_pulse(1, 40);
      wait_pulse(1, 40);
      check(k[7:0], 8'h10);
      // sysref ignored here, so the next edge keeps the free-running phase
      repeat (8) @(posedge clk);
      sref <= 1'b1;
      wait_pulse(1, 12);
      check(k[7:0], 8'h08);
      @(posedge clk);
      sref <= 1'b0;
      wreg(`ASPM_OFS_CAL_CTRL, 8'h0D);
      for (i = 0; i < 2; i++) begin
         if (i == 0) begin
            wreg(`ASPM_OFS_SOFT_TRIG, 8'h01);
         end else begin
            @(posedge clk);
            tpin <= 1'b1;
         end
         wait_pulse(2, 20);
         // pin triggers also pay the synchroniser latency, still inside the window
         check({7'h0, k + 1 >= TMIN && k + 1 <= TMAX}, 8'h01);
      end
      @(posedge clk);
      tpin <= 1'b0;
      // a countdown cut short by foreground mode must not fire later
      wreg(`ASPM_OFS_SOFT_TRIG, 8'h01);
      wreg(`ASPM_OFS_CAL_CTRL, 8'h01);
      wreg(`ASPM_OFS_SOFT_TRIG, 8'h01);
      n = 0;
      repeat (20) begin
         @(posedge clk);
         #1 n += (trans === 1'b1);
      end
      check(n[7:0], 8'h00);
      conclude;
   end
endmodule // aspm_top_tb
`default_nettype wire
